// [rtl/smsp_baud_gen.sv]
// Baud divider for the shift engine: one-cycle tick every divisor+1
// clocks while run is high. Count clears on each tick, so run may stay high between words.
`timescale 1ns/1ns
module smsp_baud_gen #(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Control
    input wire logic run,
    input wire logic [DIV_W-1:0] divisor,
    // Half-period tick
    output logic tick
);

    if (DIV_W < 8 || DIV_W > 16) begin : g_check
        $error("smsp_baud_gen: DIV_W must be 8 to 16");
    end

    typedef struct packed {
        logic [DIV_W-1:0] count;
    } smsp_baud_t;

    smsp_baud_t s_q, s_d;

    assign tick = run && (s_q.count == divisor);

    always_comb
    begin
        s_d = s_q;
        if (!run || tick)
        begin
            s_d.count = '0;
        end
        else
        begin
            s_d.count = DIV_W'(s_q.count + 1'b1);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule // smsp_baud_gen

// [rtl/smsp_pkg.sv]
// Constants for the synchronous master serial port: register indices,
// bit positions, reset values and engine states.
// Assumes an 8-bit register port addressed by register index.
package smsp_pkg;

    // ==========================================================
    // Register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] REG_TX_STATUS = 4'h0;
    localparam logic [3:0] REG_RX_STATUS = 4'h1;
    localparam logic [3:0] REG_BAUD_CTRL = 4'h2;
    localparam logic [3:0] REG_DIV_HIGH = 4'h3;
    localparam logic [3:0] REG_DIV_LOW = 4'h4;
    localparam logic [3:0] REG_TX_BUFFER = 4'h5;
    localparam logic [3:0] REG_RX_BUFFER = 4'h6;
    localparam logic [3:0] REG_PERIPH_FLAG = 4'h7;
    localparam logic [3:0] REG_PERIPH_ENABLE = 4'h8;
    localparam logic [3:0] REG_IRQ_CTRL = 4'h9;

    // ==========================================================
    // transmit_status_control bits
    localparam int TXS_MASTER_CLK = 7;
    localparam int TXS_NINE_BIT = 6;
    localparam int TXS_TX_ENABLE = 5;
    localparam int TXS_SYNC_MODE = 4;
    localparam int TXS_SHIFT_EMPTY = 1;
    localparam int TXS_NINTH_BIT = 0;

    // ==========================================================
    // receive_status_control bits
    localparam int RXS_PORT_ENABLE = 7;
    localparam int RXS_NINE_BIT = 6;
    localparam int RXS_SINGLE = 5;
    localparam int RXS_CONTINUOUS = 4;
    localparam int RXS_FRAME_ERR = 2;
    localparam int RXS_OVERRUN = 1;
    localparam int RXS_NINTH_BIT = 0;

    // ==========================================================
    // baud_control, flag, enable and interrupt control bits
    localparam int BDC_IDLE_POL = 4;
    localparam int BDC_WIDE_DIV = 3;
    localparam int PF_RX_DONE = 5;
    localparam int PF_TX_EMPTY = 4;
    localparam int IC_GLOBAL = 7;
    localparam int IC_PERIPH = 6;

    // ==========================================================
    // Word lengths and reset values
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ==========================================================
    // Shift engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TX = 2'b01,
        ST_RX = 2'b10
    } smsp_state_t;

endpackage

// [rtl/smsp_top.sv]
// Synchronous master serial port: register file, transmit buffer, shift
// engine driving clock and data pins, single and continuous reception.
// Assumes a one-cycle register port and an external slave on the pins.
//
// Operation
// - Shift register reloads from buffer only after last bit, immediately.
// - Buffer transfer takes one cycle; buffer then empty, empty flag set.
// - Buffer-empty flag sets regardless of its interrupt enable.
// - Software cannot clear buffer-empty flag; only a buffer write does.
// - Read-only shift-empty status bit, set while shifter empty, no irq.
// - Shift register is not reachable from the register port.
// - Bit rate set by 16-bit divisor and wide-divider select.
// - Master operation needs sync mode, port enable and master clock.
// - Nine-bit transmit sends the ninth data bit after eight bits.
// - Buffer write with transmit enabled starts a transmission.
// - Interrupt reaches processor only with global and peripheral enable.
// - Reception starts when single or continuous receive enable is set.
// - Receive samples data on the clock's active-to-idle edge.
// - Single receive takes one word, then stops clocking.
// - Continuous receive repeats words until software clears it.
// - Both receive enables set behaves as continuous reception.
// - Each received word sets receive-done flag and may raise irq.
// - Nine-bit receive takes a ninth bit per word.
// - Ninth bit and overrun error in status register, data in receive buffer.
// - Clearing continuous receive clears the overrun error.
// - Half-duplex: no reception while sending, no sending while receiving.
// - Master drives shift clock; port enable routes clock and data pins.
// - Clock idle level high when polarity bit set, low when clear.
`timescale 1ns/1ns
module smsp_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Register port
    input wire logic [smsp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [smsp_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [smsp_pkg::DATA_W-1:0] reg_rdata,
    // Shift clock pin
    output logic shift_clk_pin_o,
    output logic shift_clk_pin_oe,
    // Shift data pin
    input wire logic shift_data_pin_i,
    output logic shift_data_pin_o,
    output logic shift_data_pin_oe,
    // Interrupt request
    output logic irq_o
);

    // ==========================================================
    // State
    typedef struct packed {
        smsp_pkg::smsp_state_t st;
        logic master_clock_select;
        logic nine_bit_transmit;
        logic transmit_enable;
        logic sync_mode;
        logic transmit_ninth_bit;
        logic serial_port_enable;
        logic nine_bit_receive;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic overrun;
        logic received_ninth_bit;
        logic clock_idle_polarity;
        logic wide_baud_divider;
        logic [7:0] baud_divisor_high;
        logic [7:0] baud_divisor_low;
        logic [7:0] transmit_buffer;
        logic [7:0] receive_buffer;
        logic buf_full;
        logic receive_done_flag;
        logic tx_irq_enable;
        logic receive_irq_enable;
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic [8:0] tx_shift_register;
        logic [3:0] bit_cnt;
        logic half;
        logic ck;
        logic ck_oe;
        logic dt;
        logic dt_oe;
        logic [1:0] din_sync;
        logic [7:0] rdata;
    } smsp_regs_t;

    smsp_regs_t s_q, s_d;
    logic tick;
    logic master_on;
    logic rx_req;
    logic tx_flag;
    logic wr_txbuf;
    logic rd_rxbuf;
    logic [3:0] last_bit;
    logic word_end;
    logic [15:0] divisor;

    function automatic logic [3:0] last_of(input logic nine);
        return nine ? smsp_pkg::LAST_BIT_9 : smsp_pkg::LAST_BIT_8;
    endfunction

    assign master_on = s_q.serial_port_enable && s_q.sync_mode
        && s_q.master_clock_select;
    assign rx_req = s_q.single_receive_enable
        || s_q.continuous_receive_enable;
    assign tx_flag = !s_q.buf_full;
    assign wr_txbuf = reg_wr && (reg_addr == smsp_pkg::REG_TX_BUFFER);
    assign rd_rxbuf = reg_rd && (reg_addr == smsp_pkg::REG_RX_BUFFER);
    assign last_bit = (s_q.st == smsp_pkg::ST_TX)
        ? last_of(s_q.nine_bit_transmit)
        : last_of(s_q.nine_bit_receive);
    assign word_end = tick && s_q.half && (s_q.bit_cnt == last_bit);
    // Divisor 0 or 1 outruns the two-flop receive input; use 2 or more
    assign divisor = s_q.wide_baud_divider
        ? {s_q.baud_divisor_high, s_q.baud_divisor_low}
        : {smsp_pkg::RESET_BYTE, s_q.baud_divisor_low};

    // ==========================================================
    // Baud divider
    smsp_baud_gen #(
        .DIV_W(16)
    ) u_baud (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .run(s_q.st != smsp_pkg::ST_IDLE),
        .divisor(divisor),
        .tick(tick)
    );

    // ==========================================================
    // Register read mux; shifter has no address
    function automatic logic [7:0] read_reg(input smsp_regs_t r,
                                            input logic [3:0] a);
        logic [7:0] v;
        v = smsp_pkg::READ_ZERO;
        unique case (a)
            smsp_pkg::REG_TX_STATUS:
            begin
                v[smsp_pkg::TXS_MASTER_CLK] = r.master_clock_select;
                v[smsp_pkg::TXS_NINE_BIT] = r.nine_bit_transmit;
                v[smsp_pkg::TXS_TX_ENABLE] = r.transmit_enable;
                v[smsp_pkg::TXS_SYNC_MODE] = r.sync_mode;
                v[smsp_pkg::TXS_SHIFT_EMPTY] = (r.st != smsp_pkg::ST_TX);
                v[smsp_pkg::TXS_NINTH_BIT] = r.transmit_ninth_bit;
            end
            smsp_pkg::REG_RX_STATUS:
            begin
                v[smsp_pkg::RXS_PORT_ENABLE] = r.serial_port_enable;
                v[smsp_pkg::RXS_NINE_BIT] = r.nine_bit_receive;
                v[smsp_pkg::RXS_SINGLE] = r.single_receive_enable;
                v[smsp_pkg::RXS_CONTINUOUS] = r.continuous_receive_enable;
                v[smsp_pkg::RXS_OVERRUN] = r.overrun;
                v[smsp_pkg::RXS_NINTH_BIT] = r.received_ninth_bit;
            end
            smsp_pkg::REG_BAUD_CTRL:
            begin
                v[smsp_pkg::BDC_IDLE_POL] = r.clock_idle_polarity;
                v[smsp_pkg::BDC_WIDE_DIV] = r.wide_baud_divider;
            end
            smsp_pkg::REG_DIV_HIGH: v = r.baud_divisor_high;
            smsp_pkg::REG_DIV_LOW: v = r.baud_divisor_low;
            smsp_pkg::REG_TX_BUFFER: v = r.transmit_buffer;
            smsp_pkg::REG_RX_BUFFER: v = r.receive_buffer;
            smsp_pkg::REG_PERIPH_FLAG:
            begin
                v[smsp_pkg::PF_RX_DONE] = r.receive_done_flag;
                v[smsp_pkg::PF_TX_EMPTY] = !r.buf_full;
            end
            smsp_pkg::REG_PERIPH_ENABLE:
            begin
                v[smsp_pkg::PF_RX_DONE] = r.receive_irq_enable;
                v[smsp_pkg::PF_TX_EMPTY] = r.tx_irq_enable;
            end
            smsp_pkg::REG_IRQ_CTRL:
            begin
                v[smsp_pkg::IC_GLOBAL] = r.global_irq_enable;
                v[smsp_pkg::IC_PERIPH] = r.peripheral_irq_enable;
            end
            default: v = smsp_pkg::READ_ZERO;
        endcase
        return v;
    endfunction

    // ==========================================================
    // Next state: bus first, engine after so hardware sets win
    always_comb
    begin
        s_d = s_q;
        s_d.din_sync = {s_q.din_sync[0], shift_data_pin_i};
        if (reg_rd)
        begin
            s_d.rdata = read_reg(s_q, reg_addr);
        end
        if (rd_rxbuf)
        begin
            s_d.receive_done_flag = 1'b0;
        end
        if (reg_wr)
        begin
            unique case (reg_addr)
                smsp_pkg::REG_TX_STATUS:
                begin
                    s_d.master_clock_select =
                        reg_wdata[smsp_pkg::TXS_MASTER_CLK];
                    s_d.nine_bit_transmit = reg_wdata[smsp_pkg::TXS_NINE_BIT];
                    s_d.transmit_enable = reg_wdata[smsp_pkg::TXS_TX_ENABLE];
                    s_d.sync_mode = reg_wdata[smsp_pkg::TXS_SYNC_MODE];
                    s_d.transmit_ninth_bit =
                        reg_wdata[smsp_pkg::TXS_NINTH_BIT];
                end
                smsp_pkg::REG_RX_STATUS:
                begin
                    s_d.serial_port_enable =
                        reg_wdata[smsp_pkg::RXS_PORT_ENABLE];
                    s_d.nine_bit_receive = reg_wdata[smsp_pkg::RXS_NINE_BIT];
                    s_d.single_receive_enable =
                        reg_wdata[smsp_pkg::RXS_SINGLE];
                    s_d.continuous_receive_enable =
                        reg_wdata[smsp_pkg::RXS_CONTINUOUS];
                    if (!reg_wdata[smsp_pkg::RXS_CONTINUOUS])
                    begin
                        s_d.overrun = 1'b0;
                    end
                end
                smsp_pkg::REG_BAUD_CTRL:
                begin
                    s_d.clock_idle_polarity =
                        reg_wdata[smsp_pkg::BDC_IDLE_POL];
                    s_d.wide_baud_divider = reg_wdata[smsp_pkg::BDC_WIDE_DIV];
                end
                smsp_pkg::REG_DIV_HIGH: s_d.baud_divisor_high = reg_wdata;
                smsp_pkg::REG_DIV_LOW: s_d.baud_divisor_low = reg_wdata;
                smsp_pkg::REG_TX_BUFFER:
                begin
                    s_d.transmit_buffer = reg_wdata;
                    s_d.buf_full = 1'b1;
                end
                smsp_pkg::REG_PERIPH_ENABLE:
                begin
                    s_d.receive_irq_enable = reg_wdata[smsp_pkg::PF_RX_DONE];
                    s_d.tx_irq_enable = reg_wdata[smsp_pkg::PF_TX_EMPTY];
                end
                smsp_pkg::REG_IRQ_CTRL:
                begin
                    s_d.global_irq_enable = reg_wdata[smsp_pkg::IC_GLOBAL];
                    s_d.peripheral_irq_enable =
                        reg_wdata[smsp_pkg::IC_PERIPH];
                end
                // Flag register and receive buffer ignore writes
                default: s_d.rdata = s_d.rdata;
            endcase
        end

        // Shift engine
        unique case (s_q.st)
            smsp_pkg::ST_IDLE:
            begin
                if (master_on && rx_req)
                begin
                    s_d.st = smsp_pkg::ST_RX;
                    s_d.bit_cnt = '0;
                    s_d.half = 1'b0;
                    s_d.tx_shift_register = '0;
                end
                else if (master_on && s_q.transmit_enable && s_q.buf_full)
                begin
                    s_d.st = smsp_pkg::ST_TX;
                    s_d.tx_shift_register =
                        {s_q.transmit_ninth_bit, s_q.transmit_buffer};
                    s_d.bit_cnt = '0;
                    s_d.half = 1'b0;
                    s_d.buf_full = wr_txbuf;
                end
            end
            smsp_pkg::ST_TX:
            begin
                if (!master_on || !s_q.transmit_enable)
                begin
                    s_d.st = smsp_pkg::ST_IDLE;
                end
                else if (tick && !s_q.half)
                begin
                    s_d.half = 1'b1;
                end
                else if (word_end)
                begin
                    // Reload at once so back-to-back words leave no gap
                    s_d.half = 1'b0;
                    s_d.bit_cnt = '0;
                    if (s_q.buf_full && !rx_req)
                    begin
                        s_d.tx_shift_register =
                            {s_q.transmit_ninth_bit, s_q.transmit_buffer};
                        s_d.buf_full = wr_txbuf;
                    end
                    else
                    begin
                        s_d.st = smsp_pkg::ST_IDLE;
                    end
                end
                else if (tick)
                begin
                    s_d.half = 1'b0;
                    s_d.bit_cnt = 4'(s_q.bit_cnt + 1'b1);
                    s_d.tx_shift_register =
                        {1'b0, s_q.tx_shift_register[8:1]};
                end
            end
            smsp_pkg::ST_RX:
            begin
                if (!master_on || !rx_req)
                begin
                    s_d.st = smsp_pkg::ST_IDLE;
                end
                else if (tick && !s_q.half)
                begin
                    s_d.half = 1'b1;
                    s_d.tx_shift_register[s_q.bit_cnt] =
                        s_q.din_sync[1];
                end
                else if (word_end)
                begin
                    s_d.half = 1'b0;
                    s_d.bit_cnt = '0;
                    if (s_d.receive_done_flag)
                    begin
                        // Unread word is kept, the new one dropped
                        s_d.overrun = 1'b1;
                    end
                    else
                    begin
                        s_d.receive_buffer = s_q.tx_shift_register[7:0];
                        s_d.received_ninth_bit = s_q.nine_bit_receive
                            && s_q.tx_shift_register[8];
                    end
                    s_d.receive_done_flag = 1'b1;
                    if (!s_q.continuous_receive_enable)
                    begin
                        s_d.single_receive_enable = 1'b0;
                        s_d.st = smsp_pkg::ST_IDLE;
                    end
                    s_d.tx_shift_register = '0;
                end
                else if (tick)
                begin
                    s_d.half = 1'b0;
                    s_d.bit_cnt = 4'(s_q.bit_cnt + 1'b1);
                end
            end
            default: s_d.st = smsp_pkg::ST_IDLE;
        endcase

        // Pins, registered
        s_d.ck = (s_d.st != smsp_pkg::ST_IDLE && !s_d.half)
            ? !s_d.clock_idle_polarity
            : s_d.clock_idle_polarity;
        s_d.ck_oe = s_d.serial_port_enable && s_d.sync_mode
            && s_d.master_clock_select;
        s_d.dt = s_d.tx_shift_register[0];
        s_d.dt_oe = (s_d.st == smsp_pkg::ST_TX);
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
            s_q.st <= smsp_pkg::ST_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign shift_clk_pin_o = s_q.ck;
    assign shift_clk_pin_oe = s_q.ck_oe;
    assign shift_data_pin_o = s_q.dt;
    assign shift_data_pin_oe = s_q.dt_oe;
    assign irq_o = s_q.global_irq_enable && s_q.peripheral_irq_enable
        && ((tx_flag && s_q.tx_irq_enable)
        || (s_q.receive_done_flag && s_q.receive_irq_enable));

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence rx_word_done;
        s_q.st == smsp_pkg::ST_RX && rx_req && master_on && word_end;
    endsequence

    a_buffer_transfer: assert property (
        (s_q.st == smsp_pkg::ST_IDLE && master_on && !rx_req
        && s_q.transmit_enable && s_q.buf_full && !reg_wr)
        |=> (tx_flag && s_q.st == smsp_pkg::ST_TX))
        else $error("buffer not moved to shifter in one cycle");

    a_flag_no_clear: assert property (
        (tx_flag && !wr_txbuf) |=> tx_flag)
        else $error("buffer-empty flag cleared without a buffer write");

    a_shift_empty_rd: assert property (
        (reg_rd && reg_addr == smsp_pkg::REG_TX_STATUS)
        |=> reg_rdata[smsp_pkg::TXS_SHIFT_EMPTY]
            == ($past(s_q.st) != smsp_pkg::ST_TX))
        else $error("shift-empty bit disagrees with engine");

    a_single_stop: assert property (
        (rx_word_done and !s_q.continuous_receive_enable)
        |=> (s_q.st == smsp_pkg::ST_IDLE && !s_q.single_receive_enable)
            ##1 (s_q.st == smsp_pkg::ST_IDLE
            || s_q.single_receive_enable))
        else $error("single receive did not stop after one word");

    a_cont_rx_keep: assert property (
        (rx_word_done and s_q.continuous_receive_enable)
        |=> s_q.st == smsp_pkg::ST_RX && s_q.receive_done_flag)
        else $error("continuous receive stopped after a word");

    a_irq_gating: assert property (
        irq_o |-> (s_q.global_irq_enable && s_q.peripheral_irq_enable))
        else $error("interrupt without global and peripheral enable");

    a_half_duplex: assert property (
        (s_q.st == smsp_pkg::ST_RX) |-> !shift_data_pin_oe)
        else $error("data pin driven while receiving");

    a_tx_held_rx: assert property (
        (s_q.st == smsp_pkg::ST_RX && s_q.buf_full) |=> s_q.buf_full)
        else $error("transmit buffer consumed while receiving");

    a_err_cleared: assert property (
        (reg_wr && reg_addr == smsp_pkg::REG_RX_STATUS
        && !reg_wdata[smsp_pkg::RXS_CONTINUOUS] && !word_end)
        |=> !s_q.overrun)
        else $error("overrun not cleared with continuous receive");

    a_idle_clock: assert property (
        (s_q.st == smsp_pkg::ST_IDLE)[*2]
        |-> shift_clk_pin_o == s_q.clock_idle_polarity)
        else $error("clock pin not at idle level while idle");

endmodule // smsp_top

// [verification/smsp_slave_model.sv]
// Slave on the shift pins: captures master words LSB first and returns
// a word while the master clocks reception.
// Assumes the master samples on the edge back to the idle level.
`timescale 1ns/1ns
module smsp_slave_model (
    // Pins
    input wire logic clk_pin,
    input wire logic pol,
    input wire logic oe,
    input wire logic din,
    output logic dout,
    // Word side
    input wire logic [8:0] send,
    output logic [8:0] got,
    output int nb
);
    int n = 0;
    initial
    begin
        dout = 1'b0;
        got = 9'h000;
        nb = 0;
    end
    always @(clk_pin)
    begin
        if (clk_pin == pol)
        begin
            if (oe)
            begin
                got = {din, got[8:1]};
                nb++;
            end
            dout = ~dout; // Hold over: show a wrong level
        end
        else if (!oe)
        begin
            dout = send[n];
            n = (n == 8) ? 0 : n + 1;
        end
    end
endmodule // smsp_slave_model

// [verification/sync_master_serial_port_tb_top.sv]
// Testbench for the synchronous master serial port: reset, receive and
// transmit scenarios against a slave model.
// Assumes the register map and bit positions of smsp_pkg.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module sync_master_serial_port_tb_top;
    logic core_clk, arst_n, reg_wr, reg_rd, pol, sdo, cko, ckoe, dto, dtoe;
    logic irq;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, rdata, v;
    logic [8:0] got;
    int nb, n_mismatch = 0, n_tests = 0;
    wire logic din = dtoe ? dto : sdo;
    smsp_top uut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .shift_clk_pin_o(cko), .shift_clk_pin_oe(ckoe),
        .shift_data_pin_i(din), .shift_data_pin_o(dto),
        .shift_data_pin_oe(dtoe), .irq_o(irq));
    smsp_slave_model slave (.clk_pin(cko), .pol(pol), .oe(dtoe), .din(din),
        .dout(sdo), .send(9'h15A), .got(got), .nb(nb));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_bits(input int k);
        for (int i = 0; i < 3000 && nb < k; i++)
            @(posedge core_clk);
        if (nb < k)
        begin
            n_mismatch++;
            stop_test();
        end
    endtask
    task automatic wait_reg(input logic [3:0] a, input int b);
        v = 8'h00;
        for (int i = 0; i < 500 && v[b] !== 1'b1; i++)
            rd(a);
        if (v[b] !== 1'b1)
        begin
            n_mismatch++;
            stop_test();
        end
    endtask
    task automatic t_reset();
        rd(smsp_pkg::REG_TX_STATUS);
        `CHK("shift empty", 1'b1, v[smsp_pkg::TXS_SHIFT_EMPTY])
        rd(smsp_pkg::REG_PERIPH_FLAG);
        `CHK("buf empty", 1'b1, v[smsp_pkg::PF_TX_EMPTY])
        rd(4'hF);
        `CHK("unmapped", 8'h00, v)
        `CHK("clk idle", 1'b0, cko)
        $display("test reset done");
    endtask
    task automatic t_rx();
        wr(smsp_pkg::REG_DIV_LOW, 8'h03);
        wr(smsp_pkg::REG_TX_STATUS, 8'h90);
        wr(smsp_pkg::REG_BAUD_CTRL, 8'h10);
        pol = 1'b1;
        wr(smsp_pkg::REG_RX_STATUS, 8'hC0);
        repeat (3) @(posedge core_clk);
        `CHK("idle high", 1'b1, cko)
        `CHK("clk drive", 1'b1, ckoe)
        wr(smsp_pkg::REG_RX_STATUS, 8'hE0);
        wait_reg(smsp_pkg::REG_PERIPH_FLAG, smsp_pkg::PF_RX_DONE);
        rd(smsp_pkg::REG_RX_STATUS);
        `CHK("single off", 1'b0, v[smsp_pkg::RXS_SINGLE])
        `CHK("ninth", 1'b1, v[smsp_pkg::RXS_NINTH_BIT])
        rd(smsp_pkg::REG_RX_BUFFER);
        `CHK("rx data", 8'h5A, v)
        `CHK("clk stop", 1'b1, cko)
        wr(smsp_pkg::REG_RX_STATUS, 8'h80);
        wr(smsp_pkg::REG_BAUD_CTRL, 8'h00);
        pol = 1'b0;
        $display("test receive done");
    endtask
    task automatic t_tx();
        wr(smsp_pkg::REG_TX_STATUS, 8'hF1);
        wr(smsp_pkg::REG_TX_BUFFER, 8'hA5);
        wr(smsp_pkg::REG_TX_BUFFER, 8'h3C);
        rd(smsp_pkg::REG_PERIPH_FLAG);
        `CHK("buf full", 1'b0, v[smsp_pkg::PF_TX_EMPTY])
        rd(smsp_pkg::REG_TX_STATUS);
        `CHK("shift busy", 1'b0, v[smsp_pkg::TXS_SHIFT_EMPTY])
        wait_bits(9);
        `CHK("word one", 9'h1A5, got)
        wait_bits(18);
        `CHK("word two", 9'h13C, got)
        wait_reg(smsp_pkg::REG_TX_STATUS, smsp_pkg::TXS_SHIFT_EMPTY);
        wr(smsp_pkg::REG_PERIPH_FLAG, 8'h00);
        rd(smsp_pkg::REG_PERIPH_FLAG);
        `CHK("flag kept", 1'b1, v[smsp_pkg::PF_TX_EMPTY])
        wr(smsp_pkg::REG_PERIPH_ENABLE, 8'h10);
        #1 `CHK("irq gated", 1'b0, irq)
        wr(smsp_pkg::REG_IRQ_CTRL, 8'hC0);
        #1 `CHK("irq on", 1'b1, irq)
        $display("test transmit done");
    endtask
    task automatic t_cont();
        wr(smsp_pkg::REG_DIV_HIGH, 8'h01);
        wr(smsp_pkg::REG_RX_STATUS, 8'hB0);
        wr(smsp_pkg::REG_TX_BUFFER, 8'h81);
        wait_reg(smsp_pkg::REG_RX_STATUS, smsp_pkg::RXS_OVERRUN);
        `CHK("both kept", 1'b1, v[smsp_pkg::RXS_SINGLE])
        `CHK("tx held", 1'b0, dtoe)
        wr(smsp_pkg::REG_RX_STATUS, 8'h80);
        rd(smsp_pkg::REG_RX_STATUS);
        `CHK("err clear", 1'b0, v[smsp_pkg::RXS_OVERRUN])
        wait_bits(27);
        `CHK("held word", 9'h181, got)
        $display("test continuous done");
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        pol = 1'b0;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset();
        t_rx();
        t_tx();
        t_cont();
        stop_test();
    end
endmodule // sync_master_serial_port_tb_top
